// >>> common/bcdl_pkg.sv
package bcdl_pkg;
  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned OSC_HZ = 50000;
  localparam int unsigned OSC_CYCLES = CLK_HZ / OSC_HZ;
  localparam int unsigned TACH_US = 220;
  localparam int unsigned TACH_CYCLES = TACH_US * (CLK_HZ / 1000000);
  localparam int unsigned SYNC_STAGES = 3;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [2:0] HIGH_OFF_N = 3'h7;
  localparam logic [2:0] LOW_OFF = 3'h0;
  localparam logic DIR_RST = 1'h0;
  // --------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] high_n;
    logic [2:0] low;
  } bcdl_drive_t;
  typedef struct packed {
    logic comparator;
    logic peak_current;
    logic over_current;
  } bcdl_fault_t;
  // one-hot phase selection per sensor state: {high, low}
  function automatic logic [5:0] bcdl_decode(input logic [2:0] s, input logic fwd);
    logic [2:0] hi;
    logic [2:0] lo;
    hi = 3'h0;
    lo = 3'h0;
    unique case (s)
      3'h1: begin hi = 3'h1; lo = 3'h2; end
      3'h3: begin hi = 3'h1; lo = 3'h4; end
      3'h2: begin hi = 3'h2; lo = 3'h4; end
      3'h6: begin hi = 3'h2; lo = 3'h1; end
      3'h4: begin hi = 3'h4; lo = 3'h1; end
      3'h5: begin hi = 3'h4; lo = 3'h2; end
      default: begin hi = 3'h0; lo = 3'h0; end
    endcase
    return fwd ? {hi, lo} : {lo, hi};
  endfunction : bcdl_decode
endpackage : bcdl_pkg

// >>> core/bcdl_core.sv
`timescale 1ns/10ps
// Contract
// - decode three sensors and direction into three high and three low drives
// - direction goes through a latch then a two-bit shift register
// - direction latch transparent only while speed is below threshold
// - any latch or shift register mismatch forces every drive off
// - shift register advances on oscillator tick, one to two periods delay
// - a direction toggle triggers one tachometer pulse unless a pulse is already running
// - comparator clears pwm latch; cleared latch chops drives off
// - peak-current flag ends present pwm on-time
// - over-current commands soft start and holds drives off until cleared
// - low-side drive high turns its switch on
// - high-side drive low turns its switch on
// - sensor change loads position latches and starts tachometer pulse
// - position latches ignore sensors while tachometer pulse is high
module bcdl_core #(
  parameter int unsigned OSC_CYCLES = bcdl_pkg::OSC_CYCLES,
  parameter int unsigned TACH_CYCLES = bcdl_pkg::TACH_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic shaft_sensor_a,
  input wire logic shaft_sensor_b,
  input wire logic shaft_sensor_c,
  input wire logic direction_req,
  input wire logic speed_high,
  input wire logic pwm_comparator,
  input wire logic peak_current,
  input wire logic over_current,
  output logic high_side_drive_n_a,
  output logic high_side_drive_n_b,
  output logic high_side_drive_n_c,
  output logic low_side_drive_a,
  output logic low_side_drive_b,
  output logic low_side_drive_c,
  output logic tach_out,
  output logic softstart_ramp,
  output logic pwm_latch
);
  // --------------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------------
  logic [7:0] raw_in;
  logic [7:0] syn;
  logic [2:0] sensors;
  logic dir_in;
  logic speed_hi;
  bcdl_pkg::bcdl_fault_t flt;
  assign raw_in = {shaft_sensor_c, shaft_sensor_b, shaft_sensor_a, direction_req,
                   speed_high, pwm_comparator, peak_current, over_current};
  bcdl_sync #(.WIDTH(8)) u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(raw_in),
    .sync_out(syn)
  );
  assign sensors = syn[7:5];
  assign dir_in = syn[4];
  assign speed_hi = syn[3];
  assign flt = bcdl_pkg::bcdl_fault_t'(syn[2:0]);
  // --------------------------------------------------------------------
  // oscillator
  // --------------------------------------------------------------------
  logic [31:0] osc_cnt_q;
  logic osc_tick;
  assign osc_tick = (osc_cnt_q == OSC_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (srst) begin
      osc_cnt_q <= 32'h0;
    end else if (osc_tick) begin
      osc_cnt_q <= 32'h0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 32'h1;
    end
  end
  // --------------------------------------------------------------------
  // direction path
  // --------------------------------------------------------------------
  logic dir_latch_q;
  logic [1:0] dir_shift_q;
  logic dir_prev_q;
  logic dir_mismatch;
  logic dir_toggle;
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_latch_q <= bcdl_pkg::DIR_RST;
    end else if (!speed_hi) begin
      dir_latch_q <= dir_in;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_shift_q <= {2{bcdl_pkg::DIR_RST}};
    end else if (osc_tick) begin
      dir_shift_q <= {dir_shift_q[0], dir_latch_q};
    end
  end
  assign dir_mismatch = (dir_in != dir_latch_q) || (dir_latch_q != dir_shift_q[1]);
  always_ff @(posedge clk) begin
    if (srst) begin
      dir_prev_q <= bcdl_pkg::DIR_RST;
    end else begin
      dir_prev_q <= dir_in;
    end
  end
  assign dir_toggle = dir_prev_q != dir_in;
  // --------------------------------------------------------------------
  // position latch and tachometer
  // --------------------------------------------------------------------
  logic [2:0] pos_q;
  logic [31:0] tach_cnt_q;
  logic pos_load;
  assign pos_load = (sensors != pos_q) && !tach_out;
  always_ff @(posedge clk) begin
    if (srst) begin
      pos_q <= 3'h0;
    end else if (pos_load) begin
      pos_q <= sensors;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      tach_out <= 1'h0;
      tach_cnt_q <= 32'h0;
    end else if (!tach_out && (pos_load || dir_toggle)) begin
      tach_out <= 1'h1;
      tach_cnt_q <= TACH_CYCLES - 1;
    end else if (tach_cnt_q != 32'h0) begin
      tach_cnt_q <= tach_cnt_q - 32'h1;
    end else begin
      tach_out <= 1'h0;
    end
  end
  // --------------------------------------------------------------------
  // pwm latch and soft start
  // --------------------------------------------------------------------
  logic any_fault;
  assign any_fault = flt.comparator || flt.peak_current || flt.over_current;
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_latch <= 1'h0;
    end else if (any_fault) begin
      pwm_latch <= 1'h0;
    end else if (osc_tick) begin
      pwm_latch <= 1'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      softstart_ramp <= 1'h1;
    end else begin
      softstart_ramp <= flt.over_current;
    end
  end
  // --------------------------------------------------------------------
  // drive decode
  // --------------------------------------------------------------------
  bcdl_pkg::bcdl_drive_t drv_d;
  logic [5:0] sel;
  logic drive_en;
  assign sel = bcdl_pkg::bcdl_decode(pos_q, dir_shift_q[1]);
  assign drive_en = !dir_mismatch && pwm_latch && !flt.over_current;
  always_comb begin
    drv_d.high_n = drive_en ? ~sel[5:3] : bcdl_pkg::HIGH_OFF_N;
    drv_d.low = drive_en ? sel[2:0] : bcdl_pkg::LOW_OFF;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      {high_side_drive_n_c, high_side_drive_n_b, high_side_drive_n_a} <= bcdl_pkg::HIGH_OFF_N;
      {low_side_drive_c, low_side_drive_b, low_side_drive_a} <= bcdl_pkg::LOW_OFF;
    end else begin
      {high_side_drive_n_c, high_side_drive_n_b, high_side_drive_n_a} <= drv_d.high_n;
      {low_side_drive_c, low_side_drive_b, low_side_drive_a} <= drv_d.low;
    end
  end
  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  logic [2:0] high_out_n;
  logic [2:0] low_out;
  assign high_out_n = {high_side_drive_n_c, high_side_drive_n_b, high_side_drive_n_a};
  assign low_out = {low_side_drive_c, low_side_drive_b, low_side_drive_a};
  sequence s_oc;
    flt.over_current;
  endsequence
  a_oc_drives_off: assert property (@(posedge clk) disable iff (srst)
    s_oc |=> low_out == bcdl_pkg::LOW_OFF)
    else $error("drive on during over-current");
  a_oc_high_off: assert property (@(posedge clk) disable iff (srst)
    s_oc |=> high_out_n == bcdl_pkg::HIGH_OFF_N)
    else $error("high drive on during over-current");
  a_oc_softstart: assert property (@(posedge clk) disable iff (srst)
    s_oc |=> softstart_ramp)
    else $error("soft start not commanded");
  a_mismatch_off: assert property (@(posedge clk) disable iff (srst)
    dir_mismatch |=> high_out_n == bcdl_pkg::HIGH_OFF_N && low_out == bcdl_pkg::LOW_OFF)
    else $error("drive on during direction change");
  a_dir_hold: assert property (@(posedge clk) disable iff (srst)
    $past(speed_hi) |-> $stable(dir_latch_q))
    else $error("direction latch moved at speed");
  a_fault_clears: assert property (@(posedge clk) disable iff (srst)
    any_fault |=> !pwm_latch)
    else $error("pwm latch not cleared");
  a_shift_tick: assert property (@(posedge clk) disable iff (srst)
    !$past(osc_tick) |-> $stable(dir_shift_q))
    else $error("shift register moved off tick");
  a_pos_inhibit: assert property (@(posedge clk) disable iff (srst)
    tach_out |=> $stable(pos_q))
    else $error("position changed during tach pulse");
  a_tach_start: assert property (@(posedge clk) disable iff (srst)
    pos_load |=> tach_out)
    else $error("tach pulse missing");
  a_dir_tach: assert property (@(posedge clk) disable iff (srst)
    dir_toggle && !tach_out |=> tach_out)
    else $error("no tach on direction toggle");
  a_one_low: assert property (@(posedge clk) disable iff (srst)
    $countones(low_out) <= 1)
    else $error("two low drives on");
  a_one_high: assert property (@(posedge clk) disable iff (srst)
    $countones(~high_out_n) <= 1)
    else $error("two high drives on");
  a_phase_split: assert property (@(posedge clk) disable iff (srst)
    (~high_out_n & low_out) == 3'h0)
    else $error("high and low drive on one phase");
  a_pwm_set: assert property (@(posedge clk) disable iff (srst)
    osc_tick && !any_fault |=> pwm_latch)
    else $error("pwm latch not set");
endmodule : bcdl_core

// >>> core/bcdl_sync.sv
`timescale 1ns/10ps
module bcdl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_out <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change accepted once second and third stages agree
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : bcdl_sync

// >>> verification/bcdl_hall_model.sv
`timescale 1ns/10ps
module bcdl_hall_model (
  input wire logic [2:0] step,
  input wire logic bad,
  input wire logic sixty,
  output logic [2:0] hall
);
  logic [2:0] raw;
  // ------------------------------------------------------------
  // six-step walk, one sensor changes per step; 6 and 7 all low
  // ------------------------------------------------------------
  always_comb begin
    hall = 3'h0;
    raw = 3'h2;
    case (step)
      3'h0: hall = 3'h1;
      3'h1: hall = 3'h3;
      3'h2: hall = 3'h2;
      3'h3: hall = 3'h6;
      3'h4: hall = 3'h4;
      3'h5: hall = 3'h5;
      default: hall = 3'h0;
    endcase
    // 60-degree motor code; 2 turns into all low
    case (step)
      3'h0: raw = 3'h3;
      3'h1: raw = 3'h1;
      3'h2: raw = 3'h0;
      3'h3: raw = 3'h4;
      3'h4: raw = 3'h6;
      3'h5: raw = 3'h7;
      default: raw = 3'h2;
    endcase
    // sensor b inverted outside the device
    if (sixty) begin
      hall = raw ^ 3'h2;
    end
    if (bad) begin
      hall = 3'h7;
    end
  end
endmodule : bcdl_hall_model

// >>> verification/bldc_commutation_direction_logic_test.sv
`timescale 1ns/10ps
module bldc_commutation_direction_logic_test;
  localparam logic [2:0] HI [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam logic [2:0] LO [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  logic clk;
  logic srst;
  logic [2:0] step;
  logic bad;
  logic [2:0] hall;
  logic sixty;
  wire [2:0] hi_n;
  wire [2:0] lo;
  logic dir;
  logic spd;
  logic tach;
  logic ss;
  logic pl;
  bcdl_pkg::bcdl_fault_t flt;
  bcdl_pkg::bcdl_drive_t drv;
  int n_errors = 0;
  int cmp_count = 0;
  int ncyc = 0;
  int i;
  bcdl_hall_model bcdl_hall_model_inst (.step(step), .bad(bad), .sixty(sixty), .hall(hall));
  bcdl_core #(.OSC_CYCLES(10), .TACH_CYCLES(20)) bcdl_core_inst (
    .clk(clk), .srst(srst),
    .shaft_sensor_a(hall[0]), .shaft_sensor_b(hall[1]), .shaft_sensor_c(hall[2]),
    .direction_req(dir), .speed_high(spd),
    .pwm_comparator(flt.comparator), .peak_current(flt.peak_current),
    .over_current(flt.over_current),
    .high_side_drive_n_a(hi_n[0]), .high_side_drive_n_b(hi_n[1]),
    .high_side_drive_n_c(hi_n[2]),
    .low_side_drive_a(lo[0]), .low_side_drive_b(lo[1]),
    .low_side_drive_c(lo[2]),
    .tach_out(tach), .softstart_ramp(ss), .pwm_latch(pl)
  );
  assign drv = {hi_n, lo};
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [5:0] exp_drv(input int st, input logic fwd);
    if (st > 5) begin
      return 6'h38;
    end
    return fwd ? {~HI[st], LO[st]} : {~LO[st], HI[st]};
  endfunction : exp_drv
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [9:0] s, input logic [9:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    if (ncyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    srst = 1'h1;
    step = 3'h0;
    bad = 1'h0;
    sixty = 1'h0;
    dir = 1'h1;
    spd = 1'h0;
    flt = 3'h0;
    cyc(5);
    chk("reset", {ss, pl, tach, drv}, 10'h138);
    srst = 1'h0;
    cyc(60);
    for (i = 1; i <= 6; i++) begin
      step = 3'(i % 6);
      cyc(6);
      chk("tach", tach, 10'h1);
      cyc(40);
      chk("pwm", pl, 10'h1);
      chk("drv", drv, exp_drv(i % 6, 1'h1));
    end
    step = 3'h6;
    sixty = 1'h1;
    cyc(46);
    chk("drv", drv, exp_drv(6, 1'h1));
    bad = 1'h1;
    cyc(46);
    chk("drv", drv, exp_drv(6, 1'h1));
    bad = 1'h0;
    step = 3'h0;
    cyc(46);
    step = 3'h1;
    cyc(8);
    step = 3'h2;
    cyc(8);
    chk("drv", drv, exp_drv(1, 1'h1));
    cyc(50);
    chk("drv", drv, exp_drv(2, 1'h1));
    dir = 1'h0;
    cyc(8);
    chk("tach", tach, 10'h1);
    chk("drv", drv, exp_drv(6, 1'h1));
    cyc(40);
    chk("drv", drv, exp_drv(2, 1'h0));
    spd = 1'h1;
    cyc(6);
    dir = 1'h1;
    cyc(6);
    chk("tach", tach, 10'h1);
    cyc(60);
    chk("drv", drv, exp_drv(6, 1'h0));
    dir = 1'h0;
    cyc(30);
    chk("drv", drv, exp_drv(2, 1'h0));
    spd = 1'h0;
    cyc(30);
    for (i = 0; i < 3; i++) begin
      flt = 3'h4 >> i;
      cyc(20);
      chk("pwm", pl, 10'h0);
      chk("drv", drv, exp_drv(6, 1'h1));
      chk("soft", ss, {9'h0, i == 2});
      flt = 3'h0;
      cyc(40);
      chk("soft", ss, 10'h0);
      chk("drv", drv, exp_drv(2, 1'h0));
    end
    print_verdict();
  end
endmodule : bldc_commutation_direction_logic_test
